/* verilog/tcc16_timer.sv */
// Operation
// RULE1 - High counter byte goes through shared holding byte
// RULE2 - Low count read loads holding byte
// RULE3 - Low count write loads all sixteen bits
// RULE4 - Tick clears, increments or decrements per mode
// RULE5 - Clock select zero stops counter
// RULE6 - Counter accessible with or without ticks
// RULE7 - Software write beats counter update
// RULE8 - Four-bit mode split over two controls
// RULE9 - Overflow flag set at mode-dependent point
// RULE10 - Selected edge copies counter to capture
// RULE11 - Capture flag set with capture copy
// RULE12 - Capture flag interrupt; clear by ack/one
// RULE13 - Capture low read loads holding byte
// RULE14 - Capture writable only in capture-top modes
// RULE15 - Comparator select swaps capture source
// RULE16 - Software clears flag after source change
// RULE17 - Filter changes after four agreeing samples
// RULE18 - Filter enable adds four-clock delay
// RULE19 - Capture disabled in capture-top modes
// RULE20 - Driven pin level can trigger capture
// RULE21 - Software masks interrupts around paired access
// RULE22 - Holding byte reused by later writes
// RULE23 - Write high first, read low first
// RULE24 - Bottom at zero, top at sequence max
// RULE25 - Reset clears counter, capture, holding, flags
// File: 16-bit timer counter with input capture, APB slave.
// Assumes an APB master and a tick-source pin already synchronous to the system.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "tcc16_defs.svh"
module tcc16_timer
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  capture_pin,
    input  wire logic                  comparator_output,
    input  wire logic                  ext_tick,
    input  wire logic                  capture_irq_ack,
    input  wire logic                  overflow_irq_ack,
    output logic                       capture_irq,
    output logic                       overflow_irq,
    output logic                       at_bottom,
    output logic                       at_top,
    output tcc16_pkg::tcc16_word_t     count_value
);
    import tcc16_pkg::*;

    parameter bit HAS_COMPARATOR = 1'b1;

    tcc16_word_t cnt_r;
    tcc16_word_t cap_r;
    tcc16_byte_t hold_r;
    tcc16_byte_t ctrl_a_r;
    tcc16_byte_t ctrl_b_r;
    tcc16_byte_t mask_r;
    tcc16_byte_t cmp_r;
    logic        capf_r;
    logic        ovff_r;
    logic        down_r;
    logic        lvl_q_r;
    logic        capture_irq_r;
    logic        overflow_irq_r;
    logic        bottom_r;
    logic        top_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic        tick;
    logic        cap_src;
    logic        cap_lvl;
    logic        cap_ev;
    logic        acc;
    logic        wr;
    logic        rd;
    logic        hit;
    tcc16_mode_t mode;
    tcc16_word_t top_val;
    logic [2:0]  cs;

    assign acc = psel && penable;
    assign wr  = acc && pwrite;
    assign rd  = acc && !pwrite;
    assign mode = {ctrl_b_r[4:3], ctrl_a_r[1:0]}; // RULE8
    assign cs = ctrl_b_r[2:0];

    function automatic logic cap_is_top(input tcc16_mode_t m);
        cap_is_top = (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
    endfunction : cap_is_top

    function automatic logic is_updown(input tcc16_mode_t m);
        is_updown = (m[3:2] == 2'b10) || (m[3:2] == 2'b00 && m[1:0] != 2'b00);
    endfunction : is_updown

    function automatic logic is_wr(input logic [11:0] a, input logic [11:0] off, input logic w);
        is_wr = w && (a == off);
    endfunction : is_wr

    always_comb
    begin
        unique case (mode[1:0])
            2'b01:   top_val = 16'h00ff;
            2'b10:   top_val = 16'h01ff;
            2'b11:   top_val = 16'h03ff;
            default: top_val = `TCC16_MAX;
        endcase
        if (mode[3] || mode == 4'h4)
            top_val = cap_is_top(mode) ? cap_r : `TCC16_MAX;
    end

    // Clock select zero yields no ticks; other codes take the external enable
    assign tick = (cs != 3'h0) && ext_tick; // RULE5

    tcc16_filter u_filter
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .raw_in    (cap_src),
        .filter_on (ctrl_b_r[`TCC16_B_FILTER]),
        .level_out (cap_lvl)
    );

    // The pin is observed as driven, so port writes elsewhere trigger too
    assign cap_src = (HAS_COMPARATOR && cmp_r[`TCC16_B_CMPSEL]) ? comparator_output
                                                                : capture_pin; // RULE15 RULE20

    // Switching source may itself fire an edge; software clears the flag
    assign cap_ev = !cap_is_top(mode)
                    && (cap_lvl != lvl_q_r)
                    && (cap_lvl == ctrl_b_r[`TCC16_B_EDGE]); // RULE10 RULE19 RULE16

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lvl_q_r <= 1'b0;
        else
            lvl_q_r <= cap_lvl;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_r <= 16'h0000; // RULE25
        else if (is_wr(paddr, `TCC16_OFF_CNT_LO, wr))
            cnt_r <= {hold_r, pwdata[7:0]}; // RULE3 RULE6 RULE7
        else if (tick)
        begin
            // Turn here at the ends; the direction flop lags one tick
            if (cnt_r == top_val && !is_updown(mode))
                cnt_r <= 16'h0000; // RULE4
            else if (is_updown(mode) && (cnt_r == top_val || (down_r && cnt_r != 16'h0000)))
                cnt_r <= cnt_r - 16'h0001;
            else
                cnt_r <= cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            down_r <= 1'b0;
        else if (!is_updown(mode))
            down_r <= 1'b0;
        else if (tick && cnt_r == top_val)
            down_r <= 1'b1;
        else if (tick && cnt_r == 16'h0000)
            down_r <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_r <= `TCC16_RST_BYTE;
        else if (rd && paddr == `TCC16_OFF_CNT_LO)
            hold_r <= cnt_r[15:8]; // RULE2
        else if (rd && paddr == `TCC16_OFF_CAP_LO)
            hold_r <= cap_r[15:8]; // RULE13
        else if (is_wr(paddr, `TCC16_OFF_CNT_HI, wr) || is_wr(paddr, `TCC16_OFF_CAP_HI, wr))
            hold_r <= pwdata[7:0]; // RULE1 RULE22
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cap_r <= 16'h0000;
        else if (is_wr(paddr, `TCC16_OFF_CAP_LO, wr) && cap_is_top(mode))
            cap_r <= {hold_r, pwdata[7:0]}; // RULE14
        else if (cap_ev)
            cap_r <= cnt_r; // RULE10
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            capf_r <= 1'b0;
        else if (cap_ev)
            capf_r <= 1'b1; // RULE11
        else if (capture_irq_ack
                 || (is_wr(paddr, `TCC16_OFF_IRQ_FLAG, wr) && pwdata[`TCC16_B_CAPFLAG]))
            capf_r <= 1'b0; // RULE12
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ovff_r <= 1'b0;
        else if (tick && ((is_updown(mode) && cnt_r == 16'h0000 && down_r)
                          || (!is_updown(mode) && cnt_r == top_val)))
            ovff_r <= 1'b1; // RULE9
        else if (overflow_irq_ack
                 || (is_wr(paddr, `TCC16_OFF_IRQ_FLAG, wr) && pwdata[`TCC16_B_OVFFLAG]))
            ovff_r <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_a_r <= `TCC16_RST_BYTE;
            ctrl_b_r <= `TCC16_RST_BYTE;
            mask_r   <= `TCC16_RST_BYTE;
            cmp_r    <= `TCC16_RST_BYTE;
        end
        else
        begin
            if (is_wr(paddr, `TCC16_OFF_CTRL_A, wr))
                ctrl_a_r <= pwdata[7:0];
            if (is_wr(paddr, `TCC16_OFF_CTRL_B, wr))
                ctrl_b_r <= pwdata[7:0];
            if (is_wr(paddr, `TCC16_OFF_IRQ_MASK, wr))
                mask_r <= pwdata[7:0];
            if (is_wr(paddr, `TCC16_OFF_CMP_CTRL, wr))
                cmp_r <= pwdata[7:0];
        end
    end

    always_comb
    begin
        hit = 1'b1;
        unique case (paddr)
            `TCC16_OFF_CTRL_A, `TCC16_OFF_CTRL_B, `TCC16_OFF_CNT_LO, `TCC16_OFF_CNT_HI,
            `TCC16_OFF_CAP_LO, `TCC16_OFF_CAP_HI, `TCC16_OFF_IRQ_MASK,
            `TCC16_OFF_IRQ_FLAG, `TCC16_OFF_CMP_CTRL: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= 32'h00000000;
        else if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                `TCC16_OFF_CTRL_A:   prdata_r <= {24'h000000, ctrl_a_r};
                `TCC16_OFF_CTRL_B:   prdata_r <= {24'h000000, ctrl_b_r};
                `TCC16_OFF_CNT_LO:   prdata_r <= {24'h000000, cnt_r[7:0]};
                `TCC16_OFF_CAP_LO:   prdata_r <= {24'h000000, cap_r[7:0]};
                `TCC16_OFF_CNT_HI,
                `TCC16_OFF_CAP_HI:   prdata_r <= {24'h000000, hold_r}; // RULE1
                `TCC16_OFF_IRQ_MASK: prdata_r <= {24'h000000, mask_r};
                `TCC16_OFF_IRQ_FLAG: prdata_r <= {26'h0000000, capf_r, 4'h0, ovff_r};
                `TCC16_OFF_CMP_CTRL: prdata_r <= {24'h000000, cmp_r};
                default:             prdata_r <= 32'h00000000;
            endcase
        end
    end

    // Registered so the error stands for exactly the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr_r <= 1'b0;
        else
            pslverr_r <= psel && !penable && !hit;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            capture_irq_r  <= 1'b0;
            overflow_irq_r <= 1'b0;
            bottom_r       <= 1'b0;
            top_r          <= 1'b0;
        end
        else
        begin
            capture_irq_r  <= capf_r && mask_r[`TCC16_B_CAPFLAG]; // RULE12
            overflow_irq_r <= ovff_r && mask_r[`TCC16_B_OVFFLAG]; // RULE9
            bottom_r       <= (cnt_r == 16'h0000); // RULE24
            top_r          <= (cnt_r == top_val); // RULE24
        end
    end

    assign prdata      = prdata_r;
    assign pready      = 1'b1;
    assign pslverr     = pslverr_r;
    assign capture_irq = capture_irq_r;
    assign overflow_irq = overflow_irq_r;
    assign at_bottom   = bottom_r;
    assign at_top      = top_r;
    assign count_value = cnt_r;

    chk_cap_copy: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
        cap_ev && !(wr && paddr == `TCC16_OFF_CAP_LO) |=> (cap_r == $past(cnt_r)) && capf_r)
        else $error("capture did not copy counter with flag");
    chk_cap_flag: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
        $rose(capf_r) |-> $past(cap_ev))
        else $error("capture flag rose without event");
    chk_cnt_write: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        wr && paddr == `TCC16_OFF_CNT_LO |=> cnt_r == {$past(hold_r), $past(pwdata[7:0])})
        else $error("low count write lost");
    chk_hold_load: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        rd && paddr == `TCC16_OFF_CNT_LO |=> hold_r == $past(cnt_r[15:8]))
        else $error("holding byte not loaded on low read");
    chk_stop_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        cs == 3'h0 && !wr |=> $stable(cnt_r))
        else $error("counter moved while stopped");
    chk_no_capture: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
        cap_is_top(mode) && !(wr && paddr == `TCC16_OFF_CAP_LO)
        |=> $stable(cap_r) && !$rose(capf_r))
        else $error("capture fired in capture-top mode");
    chk_cap_guard: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
        wr && paddr == `TCC16_OFF_CAP_LO && !cap_is_top(mode) && !cap_ev |=> $stable(cap_r))
        else $error("capture written outside capture-top mode");
    chk_count_step: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        tick && !wr && !down_r && cnt_r != top_val |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("counter did not step");
    chk_turn_top: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        tick && !wr && is_updown(mode) && cnt_r == top_val |=> cnt_r == $past(cnt_r) - 16'h0001)
        else $error("up/down count did not turn at top");
endmodule : tcc16_timer
`default_nettype wire

/* verilog/tcc16_defs.svh */
// Constants for the 16-bit timer counter with input capture.
// Assumes an APB bus of 32-bit words; each register is one aligned word.
`ifndef TCC16_DEFS_SVH
`define TCC16_DEFS_SVH
`define TCC16_OFF_CTRL_A    12'h000
`define TCC16_OFF_CTRL_B    12'h004
`define TCC16_OFF_CNT_LO    12'h008
`define TCC16_OFF_CNT_HI    12'h00c
`define TCC16_OFF_CAP_LO    12'h010
`define TCC16_OFF_CAP_HI    12'h014
`define TCC16_OFF_IRQ_MASK  12'h018
`define TCC16_OFF_IRQ_FLAG  12'h01c
`define TCC16_OFF_CMP_CTRL  12'h020
`define TCC16_OFF_IRQ_ACK   12'h024
`define TCC16_B_EDGE        6
`define TCC16_B_FILTER      7
`define TCC16_B_CAPFLAG     5
`define TCC16_B_OVFFLAG     0
`define TCC16_B_CMPSEL      2
`define TCC16_FILT_SAMPLES  4
`define TCC16_MAX           16'hffff
`define TCC16_RST_BYTE      8'h00
`endif

/* verilog/tcc16_pkg.sv */
// Types for the 16-bit timer counter with input capture.
// Assumes the constants header is compiled alongside.
package tcc16_pkg;
    typedef logic [15:0] tcc16_word_t;
    typedef logic [7:0]  tcc16_byte_t;
    typedef logic [3:0]  tcc16_mode_t;
endpackage : tcc16_pkg

/* verilog/tcc16_filter.sv */
// Capture input conditioning: three-stage sync, optional four-sample filter.
// Assumes the input is asynchronous to pclk.
`timescale 1ns/10ps
`default_nettype none
`include "tcc16_defs.svh"
module tcc16_filter
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic raw_in,
    input  wire logic filter_on,
    output logic      level_out
);
    logic       s1_r;
    logic       s2_r;
    logic       s3_r;
    logic       lvl_r;
    logic [3:0] hist_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end
        else
        begin
            s1_r <= raw_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hist_r <= 4'h0;
        else if (s2_r == s3_r)
            hist_r <= {hist_r[2:0], s3_r};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lvl_r <= 1'b0;
        else if (!filter_on)
        begin
            if (s2_r == s3_r)
                lvl_r <= s3_r;
        end
        else if (hist_r == 4'hf || hist_r == 4'h0) // RULE17 RULE18
            lvl_r <= hist_r[3];
    end

    assign level_out = lvl_r;

    chk_filter_agree: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
        (filter_on && $past(filter_on) && lvl_r != $past(lvl_r))
        |-> ($past(hist_r) == 4'hf || $past(hist_r) == 4'h0))
        else $error("filter output changed without four agreeing samples");
endmodule : tcc16_filter
`default_nettype wire

/* bench/tcc16_cpu_model.sv */
// CPU-side partner: APB master tasks, paired byte access, interrupt acknowledge.
// Assumes pclk from the bench; every task starts at the next rising edge.
`timescale 1ns/10ps
`default_nettype none
`include "tcc16_defs.svh"
module tcc16_cpu_model
(
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    output logic             capture_irq_ack,
    output logic             overflow_irq_ack
);
    // Service waits while a pair is open, or the holding byte is lost
    logic pair_busy = 1'b0;
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {capture_irq_ack, overflow_irq_ack} = 2'b00;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released data shows the inverse, not a stale copy
        pwdata  <= ~d;
    endtask : xfer
    task automatic wr8(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, a, {24'h000000, d}, q, e);
    endtask : wr8
    task automatic rd8(input logic [11:0] a, output logic [7:0] v);
        logic [31:0] q;
        logic        e;
        xfer(1'b0, a, 32'h00000000, q, e);
        v = q[7:0];
    endtask : rd8
    task automatic wr16(input logic [11:0] lo, input logic [15:0] v);
        pair_busy = 1'b1;
        wr8(lo + 12'h004, v[15:8]);
        wr8(lo, v[7:0]);
        pair_busy = 1'b0;
    endtask : wr16
    task automatic rd16(input logic [11:0] lo, output logic [15:0] v);
        pair_busy = 1'b1;
        rd8(lo, v[7:0]);
        rd8(lo + 12'h004, v[15:8]);
        pair_busy = 1'b0;
    endtask : rd16
    task automatic ack_irq(input logic cap);
        @(posedge pclk);
        while (pair_busy)
            @(posedge pclk);
        capture_irq_ack  <= cap;
        overflow_irq_ack <= ~cap;
        @(posedge pclk);
        capture_irq_ack  <= 1'b0;
        overflow_irq_ack <= 1'b0;
    endtask : ack_irq
    task automatic select_source(input logic cmp);
        wr8(`TCC16_OFF_CMP_CTRL, 8'(cmp) << `TCC16_B_CMPSEL);
        wr8(`TCC16_OFF_IRQ_FLAG, 8'h20);
    endtask : select_source
endmodule : tcc16_cpu_model
`default_nettype wire

/* bench/timer16_counter_capture_tb_top.sv */
// Self-checking bench for the timer counter with capture.
// Assumes the design and its header and package are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "tcc16_defs.svh"
module timer16_counter_capture_tb_top;
    import tcc16_pkg::*;
    localparam logic [11:0] CB = `TCC16_OFF_CTRL_B;
    localparam logic [11:0] CL = `TCC16_OFF_CNT_LO;
    localparam logic [11:0] PL = `TCC16_OFF_CAP_LO;
    localparam logic [11:0] FL = `TCC16_OFF_IRQ_FLAG;
    logic        pclk = 1'b0, presetn = 1'b0, capture_pin = 1'b0;
    logic        comparator_output = 1'b0, ext_tick = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, c_ack, o_ack;
    logic        capture_irq, overflow_irq, at_bottom, at_top, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] v;
    logic [7:0]  b;
    tcc16_word_t count_value;
    int          err_total = 0, checked = 0, cyc = 0, lat0, lat1;
    logic [15:0] rows [4][2] = '{'{16'h01ff, 16'h01ff}, '{16'h0000, 16'h0000},
                                 '{16'hffff, 16'hffff}, '{16'ha55a, 16'ha55a}};
    tcc16_timer #(.HAS_COMPARATOR(1'b1)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
        .comparator_output(comparator_output), .ext_tick(ext_tick),
        .capture_irq_ack(c_ack), .overflow_irq_ack(o_ack), .capture_irq(capture_irq),
        .overflow_irq(overflow_irq), .at_bottom(at_bottom), .at_top(at_top),
        .count_value(count_value));
    tcc16_cpu_model cpu (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .capture_irq_ack(c_ack), .overflow_irq_ack(o_ack));
    initial
    begin
        forever #20 pclk = ~pclk;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    task automatic settle(input int n);
        repeat (n) @(negedge pclk);
    endtask : settle
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            ext_tick <= 1'b1;
            @(posedge pclk);
            ext_tick <= 1'b0;
        end
    endtask : tick
    task automatic wait_irq(output int n);
        n = 0;
        while (capture_irq !== 1'b1 && n < 40)
        begin
            @(negedge pclk);
            n++;
        end
    endtask : wait_irq
    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        settle(1);
        check("count", count_value, 16'h0000);
        cpu.rd8(CL + 12'h004, b);
        check("hold", b, 8'h00);
        cpu.rd16(PL, v);
        check("capture", v, 16'h0000);
        cpu.rd8(FL, b);
        check("flags", b, 8'h00);
        check("ready", pready, 1'b1);
        cpu.wr8(`TCC16_OFF_CTRL_A, 8'h00);
        foreach (rows[i])
        begin
            cpu.wr16(CL, rows[i][0]);
            settle(1);
            check("count port", count_value, rows[i][1]);
            cpu.rd16(CL, v);
            check("count read", v, rows[i][1]);
        end
        $display("done: reset and access");
        cpu.wr8(CB, 8'h01);
        cpu.wr16(CL, 16'h00fe);
        tick(3);
        settle(1);
        check("count up", count_value, 16'h0101);
        cpu.wr8(CB, 8'h00);
        tick(2);
        settle(1);
        check("count held", count_value, 16'h0101);
        cpu.wr8(CB, 8'h01);
        cpu.wr8(`TCC16_OFF_CTRL_A, 8'h01);
        cpu.wr16(CL, 16'h00fe);
        tick(3);
        settle(1);
        check("count down", count_value, 16'h00fd);
        cpu.wr8(`TCC16_OFF_CTRL_A, 8'h00);
        cpu.wr8(CL + 12'h004, 8'h12);
        @(posedge pclk);
        ext_tick <= 1'b1;
        cpu.xfer(1'b1, CL, 32'h00000034, q, e);
        ext_tick <= 1'b0;
        settle(1);
        check("write wins", count_value, 16'h1234);
        cpu.wr8(`TCC16_OFF_IRQ_MASK, 8'h01);
        cpu.wr16(CL, 16'hffff);
        settle(2);
        check("top", at_top, 1'b1);
        tick(1);
        settle(2);
        check("wrap", count_value, 16'h0000);
        check("bottom", at_bottom, 1'b1);
        check("ovf irq", overflow_irq, 1'b1);
        cpu.ack_irq(1'b0);
        cpu.rd8(FL, b);
        check("ovf ack", b[0], 1'b0);
        $display("done: counting");
        cpu.wr8(CB, 8'h40);
        cpu.wr8(`TCC16_OFF_IRQ_MASK, 8'h20);
        cpu.wr8(FL, 8'h21);
        cpu.wr16(CL, 16'h5a3c);
        @(posedge pclk);
        capture_pin <= 1'b1;
        wait_irq(lat0);
        check("cap irq", capture_irq, 1'b1);
        cpu.rd8(FL, b);
        check("cap flag", b[5], 1'b1);
        cpu.rd16(PL, v);
        check("cap value", v, 16'h5a3c);
        cpu.wr16(CL, 16'h2222);
        @(posedge pclk);
        capture_pin <= 1'b0;
        settle(12);
        cpu.rd16(PL, v);
        check("wrong edge", v, 16'h5a3c);
        cpu.wr8(CB, 8'hc0);
        cpu.wr8(FL, 8'h21);
        @(posedge pclk);
        capture_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        capture_pin <= 1'b0;
        settle(16);
        check("glitch", capture_irq, 1'b0);
        @(posedge pclk);
        capture_pin <= 1'b1;
        wait_irq(lat1);
        check("filter delay", lat1 - lat0, 4);
        cpu.rd16(PL, v);
        check("filtered cap", v, 16'h2222);
        $display("done: capture pin");
        cpu.select_source(1'b1);
        cpu.wr16(CL, 16'h3333);
        @(posedge pclk);
        comparator_output <= 1'b1;
        wait_irq(lat1);
        cpu.rd16(PL, v);
        check("cmp cap", v, 16'h3333);
        cpu.ack_irq(1'b1);
        cpu.rd8(FL, b);
        check("cap ack", b[5], 1'b0);
        cpu.wr8(CB, 8'h18);
        cpu.wr16(PL, 16'h0123);
        cpu.rd16(PL, v);
        check("cap write", v, 16'h0123);
        cpu.wr8(FL, 8'h21);
        @(posedge pclk);
        comparator_output <= 1'b0;
        settle(16);
        check("no trigger", capture_irq, 1'b0);
        cpu.wr8(CL, 8'h45);
        settle(1);
        check("hold reuse", count_value, 16'h0145);
        cpu.wr8(CB, 8'h00);
        cpu.wr16(PL, 16'h7777);
        cpu.rd16(PL, v);
        check("cap locked", v, 16'h0123);
        cpu.xfer(1'b0, 12'h024, 32'h00000000, q, e);
        check("unmapped err", e, 1'b1);
        check("unmapped data", q, 32'h00000000);
        $display("done: source and modes");
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        settle(1);
        check("rst count", count_value, 16'h0000);
        cpu.rd16(PL, v);
        check("rst capture", v, 16'h0000);
        $display("done: second reset");
        print_verdict();
    end
endmodule : timer16_counter_capture_tb_top
`default_nettype wire
